// ---- logic/dbfr_pkg.sv ----
/*
 * dbfr_pkg: constants for the debug breakpoint and force-reset block.
 * Assumes an 8-bit debug/CPU data path and a 16-bit CPU address bus.
 */
package dbfr_pkg;
	localparam int          DBFR_ADDR_W        = 16;
	localparam int          DBFR_DATA_W        = 8;
	localparam logic [15:0] DBFR_BKPT_RST      = 16'h0000;
	localparam logic [15:0] DBFR_FRC_RST_ADDR  = 16'h1801;
	localparam int          DBFR_FRC_BIT       = 0;
	localparam logic [7:0]  DBFR_FRC_READ_VAL  = 8'h00;
	localparam logic [7:0]  DBFR_FRC_RST_VAL   = 8'h00;
	localparam int          DBFR_SCR_BREAKPOINT_ENABLE    = 5;
	localparam int          DBFR_SCR_FTS       = 4;
	localparam int          DBFR_RST_PULSE     = 4;
endpackage : dbfr_pkg

// ---- logic/dbfr_top.sv ----
/*
 * dbfr_top: breakpoint match register, breakpoint comparator and the
 * write-only force-reset register of the background debug controller.
 * Assumes the serial command engine decodes commands and presents one-cycle
 * strobes on clk_i, and that the system reset generator widens mcu_reset_o.
 */
`timescale 1ns/10ps
module dbfr_top #(
	parameter int RST_PULSE = dbfr_pkg::DBFR_RST_PULSE
) (
	input  wire logic                             clk_i,
	input  wire logic                             sys_rst_i,
	input  wire logic                             write_breakpoint_cmd_i,
	input  wire logic                             read_breakpoint_cmd_i,
	input  wire logic [dbfr_pkg::DBFR_ADDR_W-1:0] bkpt_wdata_i,
	output logic      [dbfr_pkg::DBFR_ADDR_W-1:0] bkpt_rdata_o,
	input  wire logic                             breakpoint_enable_i,
	input  wire logic                             force_or_tag_select_i,
	input  wire logic                             mem_wr_i,
	input  wire logic                             mem_rd_i,
	input  wire logic                             mem_from_debug_i,
	input  wire logic [dbfr_pkg::DBFR_ADDR_W-1:0] mem_addr_i,
	input  wire logic [dbfr_pkg::DBFR_DATA_W-1:0] mem_wdata_i,
	output logic      [dbfr_pkg::DBFR_DATA_W-1:0] mem_rdata_o,
	output logic                                  mem_rsel_o,
	input  wire logic [dbfr_pkg::DBFR_ADDR_W-1:0] cpu_addr_i,
	input  wire logic                             cpu_fetch_i,
	input  wire logic                             cpu_boundary_i,
	input  wire logic                             cpu_exec_i,
	output logic                                  bkpt_force_o,
	output logic                                  bkpt_tag_o,
	output logic                                  bkpt_request_o,
	output logic                                  mcu_reset_o
);
	import dbfr_pkg::*;

	logic [DBFR_ADDR_W-1:0] match_addr_q;
	logic                   force_pend_q;
	logic                   tag_q;
	logic [2:0]             rst_cnt_q;
	logic                   addr_hit;
	logic                   frc_sel;
	logic                   frc_set;

	// the pulse counter is three bits wide; an empty or longer pulse cannot be served
	if (RST_PULSE < 1 || RST_PULSE > 7) begin : g_pulse_chk
		$error("reset pulse length out of range");
	end

	// match register: written only by the serial command strobe, never the memory bus
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			match_addr_q <= DBFR_BKPT_RST;
		end else if (write_breakpoint_cmd_i) begin
			match_addr_q <= bkpt_wdata_i;
		end
	end

	// read answer for the serial read-breakpoint command
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bkpt_rdata_o <= DBFR_BKPT_RST;
		end else if (read_breakpoint_cmd_i) begin
			bkpt_rdata_o <= match_addr_q;
		end
	end

	// comparator is gated by the enable so select and address are don't-care when off
	assign addr_hit = breakpoint_enable_i && (cpu_addr_i == match_addr_q);

	// force mode: pend the request until the next instruction boundary
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			force_pend_q <= 1'b0;
		end else if (!breakpoint_enable_i) begin
			force_pend_q <= 1'b0;
		end else if (addr_hit && force_or_tag_select_i) begin
			force_pend_q <= 1'b1;
		end else if (cpu_boundary_i) begin
			force_pend_q <= 1'b0;
		end
	end

	// tag mode: tag the fetched opcode; dropped once an opcode executes without a new tagged fetch
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tag_q <= 1'b0;
		end else if (!breakpoint_enable_i) begin
			tag_q <= 1'b0;
		end else if (addr_hit && !force_or_tag_select_i && cpu_fetch_i) begin
			tag_q <= 1'b1;
		end else if (cpu_exec_i) begin
			tag_q <= 1'b0;
		end
	end

	// force and request outputs gated by the enable too: a pend left from before a disable must not leak out
	assign bkpt_force_o   = breakpoint_enable_i && force_pend_q && cpu_boundary_i;
	assign bkpt_tag_o     = tag_q;
	assign bkpt_request_o = bkpt_force_o || (breakpoint_enable_i && tag_q && cpu_exec_i);

	// force-reset register decode; the match register has no memory address at all
	assign frc_sel = (mem_addr_i == DBFR_FRC_RST_ADDR);
	assign frc_set = mem_wr_i && frc_sel && mem_from_debug_i
	                 && mem_wdata_i[DBFR_FRC_BIT];

	// reads return zero; no storage exists, so nothing written can leak back
	assign mem_rsel_o  = mem_rd_i && frc_sel;
	assign mem_rdata_o = DBFR_FRC_READ_VAL;

	// reset pulse generator; the pulse does not clear this block, only sys_rst_i resets it
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_cnt_q <= 3'h0;
		end else if (frc_set) begin
			rst_cnt_q <= 3'(RST_PULSE);
		end else if (rst_cnt_q != 3'h0) begin
			rst_cnt_q <= rst_cnt_q - 3'h1;
		end
	end

	assign mcu_reset_o = (rst_cnt_q != 3'h0);

	// helper: cycles the current reset pulse has stood, restarted by every trigger
	logic [3:0] pulse_len_q;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pulse_len_q <= 4'h0;
		end else if (frc_set) begin
			pulse_len_q <= 4'h1;
		end else if (mcu_reset_o) begin
			pulse_len_q <= pulse_len_q + 4'h1;
		end else begin
			pulse_len_q <= 4'h0;
		end
	end

	// the breakpoint modes as steps: a force-mode hit, a tagged fetch, a tagged execute
	sequence force_hit_s;
		addr_hit && force_or_tag_select_i;
	endsequence
	sequence tag_fetch_s;
		addr_hit && !force_or_tag_select_i && cpu_fetch_i;
	endsequence
	sequence tag_exec_s;
		breakpoint_enable_i && bkpt_tag_o && cpu_exec_i;
	endsequence

	// a serial write of one starts the reset pulse on the next edge
	frc_reset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		frc_set |=> mcu_reset_o) else $error("force reset did not assert");
	// a user-program write never causes a reset pulse
	user_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(mem_wr_i && !mem_from_debug_i && rst_cnt_q == 3'h0) |=> !mcu_reset_o)
		else $error("user write caused reset");
	// read data is always zero
	read_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		mem_rsel_o |-> mem_rdata_o == 8'h00) else $error("force reset read not zero");
	// match register follows the serial write command
	bkpt_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		write_breakpoint_cmd_i |=> match_addr_q == $past(bkpt_wdata_i))
		else $error("breakpoint write lost");
	// match register stable without the serial command
	bkpt_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!write_breakpoint_cmd_i |=> $stable(match_addr_q)) else $error("breakpoint changed");
	// disabled breakpoint raises nothing
	bkpt_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!breakpoint_enable_i |=> !bkpt_request_o && !bkpt_tag_o) else $error("disabled breakpoint fired");
	// tag mode: fetch hit tags the opcode
	tag_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(addr_hit && !force_or_tag_select_i && cpu_fetch_i) ##1 breakpoint_enable_i |-> bkpt_tag_o)
		else $error("opcode not tagged");
	// force mode: hit then boundary yields request
	force_req_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(addr_hit && force_or_tag_select_i) ##1 (breakpoint_enable_i && cpu_boundary_i) |-> bkpt_request_o)
		else $error("forced breakpoint missed");
	// the force and request outputs go quiet in the same cycle the enable drops
	off_now_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!breakpoint_enable_i |-> !bkpt_request_o && !bkpt_force_o)
		else $error("disabled breakpoint requested");
	// the read answer stands until the next read command
	rdata_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!read_breakpoint_cmd_i |=> $stable(bkpt_rdata_o))
		else $error("breakpoint read data changed");
	// a read command returns the stored match address
	bkpt_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		read_breakpoint_cmd_i |=> bkpt_rdata_o == $past(match_addr_q))
		else $error("breakpoint read wrong");
	// the reset pulse never outlasts its programmed length
	pulse_range_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		mcu_reset_o |-> pulse_len_q >= 4'h1 && pulse_len_q <= 4'(RST_PULSE))
		else $error("reset pulse too long");
	// a pulse that is not retriggered ends after exactly its programmed length
	pulse_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(mcu_reset_o) |-> $past(pulse_len_q) == 4'(RST_PULSE))
		else $error("reset pulse length wrong");
	// a force-mode hit pends the request until a boundary comes
	force_pend_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		force_hit_s |=> force_pend_q)
		else $error("forced hit not pended");
	// a tagged fetch shows on the tag output in the next cycle
	tag_fetch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		tag_fetch_s |=> bkpt_tag_o)
		else $error("fetch hit not tagged");
	// executing a tagged opcode raises the break request at once
	tag_exec_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		tag_exec_s |-> bkpt_request_o)
		else $error("tagged opcode executed without request");
	// any executed opcode drops the tag unless a new tagged fetch overlaps it
	tag_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cpu_exec_i && !(addr_hit && !force_or_tag_select_i && cpu_fetch_i)) |=> !bkpt_tag_o)
		else $error("tag kept after execute");
endmodule : dbfr_top

// ---- tb/dbfr_host_model.sv ----
/* dbfr_host_model: debug host issuing breakpoint commands and memory accesses.
 * Assumes the bench calls its tasks; requests change only at falling edges. */
`timescale 1ns/10ps
module dbfr_host_model (
	input  wire logic        clk_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic [15:0]      wd_o,
	input  wire logic [15:0] rd_i,
	output logic             mwr_o,
	output logic             mrd_o,
	output logic             dbg_o,
	output logic [15:0]      ma_o,
	output logic [7:0]       mwd_o,
	input  wire logic [7:0]  mrd_i
);
	// idle with no strobe raised
	initial {wr_o, rd_o, wd_o, mwr_o, mrd_o, dbg_o, ma_o, mwd_o} = '0;
	// one strobe; released data is inverted so stale values never match
	task automatic bkpt_cmd(input logic w, input logic [15:0] d, output logic [15:0] q);
		@(negedge clk_i);
		{wr_o, rd_o, wd_o} = {w, ~w, d};
		@(negedge clk_i);
		{wr_o, rd_o, wd_o} = {2'b00, ~d};
		q = rd_i;
	endtask : bkpt_cmd
	// dbg marks a serial byte write; the answer is taken at the rising edge
	task automatic mem_acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic dbg,
		output logic [7:0] q);
		@(negedge clk_i);
		{mwr_o, mrd_o, dbg_o, ma_o, mwd_o} = {w, ~w, dbg, a, d};
		@(posedge clk_i);
		q = mrd_i;
		@(negedge clk_i);
		{mwr_o, mrd_o, dbg_o, ma_o, mwd_o} = {2'b00, ~dbg, ~a, ~d};
	endtask : mem_acc
endmodule : dbfr_host_model

// ---- tb/testbench.sv ----
/* testbench: breakpoint and force-reset checks through the host model and cpu side.
 * Assumes the package and host model are compiled first. */
`timescale 1ns/10ps
module testbench;
	import dbfr_pkg::*;
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, en = 1'b0, force_or_tag_select = 1'b0, fe = 1'b0, bd = 1'b0, ex = 1'b0;
	logic        wr, rd, mwr, mrd, dbg, frc, tag, req, rst, rsel, sel_q;
	logic [15:0] wd, rdat, ma, ca = 16'h0000, q, n;
	logic [7:0]  mwd, mrdat, b;
	int          err_count = 0, n_tests = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	// read-select as seen at the edge that takes the read answer
	always @(posedge clk_i) sel_q <= rsel;
	dbfr_top dbfr_top_i (.clk_i, .sys_rst_i, .write_breakpoint_cmd_i(wr), .read_breakpoint_cmd_i(rd),
		.bkpt_wdata_i(wd), .bkpt_rdata_o(rdat), .breakpoint_enable_i(en), .force_or_tag_select_i(force_or_tag_select),
		.mem_wr_i(mwr), .mem_rd_i(mrd), .mem_from_debug_i(dbg), .mem_addr_i(ma), .mem_wdata_i(mwd),
		.mem_rdata_o(mrdat), .mem_rsel_o(rsel), .cpu_addr_i(ca), .cpu_fetch_i(fe), .cpu_boundary_i(bd),
		.cpu_exec_i(ex), .bkpt_force_o(frc), .bkpt_tag_o(tag), .bkpt_request_o(req), .mcu_reset_o(rst));
	dbfr_host_model dbfr_host_model_i (.clk_i, .wr_o(wr), .rd_o(rd), .wd_o(wd), .rd_i(rdat), .mwr_o(mwr),
		.mrd_o(mrd), .dbg_o(dbg), .ma_o(ma), .mwd_o(mwd), .mrd_i(mrdat));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic close_out;
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	// cycles with the chip reset raised, counting the current one
	task automatic rst_cnt(input logic [15:0] e);
		n = 16'h0000;
		repeat (7) begin
			n = n + {15'h0000, rst};
			@(negedge clk_i);
		end
		chk(n, e);
	endtask : rst_cnt
	// a hung handshake would otherwise stall the run forever
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		repeat (5) @(negedge clk_i);
		sys_rst_i = 1'b0;
		dbfr_host_model_i.bkpt_cmd(1'b1, 16'hA5C3, q);
		dbfr_host_model_i.bkpt_cmd(1'b0, 16'h0000, q);
		chk(q, 16'hA5C3);
		dbfr_host_model_i.mem_acc(1'b1, DBFR_FRC_RST_ADDR, 8'hFF, 1'b0, b);
		rst_cnt(16'h0000);
		dbfr_host_model_i.mem_acc(1'b0, DBFR_FRC_RST_ADDR, 8'h00, 1'b1, b);
		chk({7'h00, sel_q, b}, 16'h0100);
		dbfr_host_model_i.bkpt_cmd(1'b0, 16'h0000, q);
		chk(q, 16'hA5C3);
		{en, force_or_tag_select, ca} = {2'b11, 16'hA5C3};
		@(negedge clk_i);
		bd = 1'b1;
		#1 chk({14'h0000, frc, req}, 16'h0003);
		@(negedge clk_i);
		{bd, force_or_tag_select, fe} = 3'b001;
		@(negedge clk_i);
		{fe, ex} = 2'b01;
		#1 chk({14'h0000, tag, req}, 16'h0003);
		@(negedge clk_i);
		{ex, en, force_or_tag_select, bd} = 4'b0011;
		#1 chk({14'h0000, frc, req}, 16'h0000);
		@(negedge clk_i);
		#1 chk({13'h0000, frc, req, tag}, 16'h0000);
		@(negedge clk_i);
		bd = 1'b0;
		dbfr_host_model_i.mem_acc(1'b1, DBFR_FRC_RST_ADDR, 8'hFE, 1'b1, b);
		rst_cnt(16'h0000);
		dbfr_host_model_i.mem_acc(1'b1, DBFR_FRC_RST_ADDR, 8'h01, 1'b1, b);
		rst_cnt(16'h0004);
		// mid-run reset: match register and answers go back to their reset values
		sys_rst_i = 1'b1;
		@(negedge clk_i);
		sys_rst_i = 1'b0;
		#1 chk(rdat, DBFR_BKPT_RST);
		chk({12'h000, frc, req, tag, rst}, 16'h0000);
		dbfr_host_model_i.bkpt_cmd(1'b0, 16'h0000, q);
		chk(q, DBFR_BKPT_RST);
		close_out();
	end
endmodule : testbench
